// ### swa_pkg.sv
// Constants and carrier types for the secondary wide extension and arbiter
`default_nettype none
package swa_pkg;
    localparam int ADDR_W = 8;
    localparam int NREQ = 9;
    localparam int NARB = 10;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
    localparam int CTRL_ARB_EN = 0;
    localparam int CTRL_LOW_LSB = 16;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] CTRL_MASK = 32'h03FF_0001;
    localparam int STAT_EXT_EN = 0;
    localparam int STAT_PERR = 1;
    localparam int STAT_IDX_LSB = 4;
    localparam int STAT_GVALID = 8;
    localparam int STAT_EXT_MODE = 9;
    localparam logic [3:0] OWN_IDX = 4'h9;
    localparam logic [3:0] LOW_SLOT = 4'hA;
    localparam logic [3:0] HI_N = 4'hB;
    localparam logic [3:0] LO_N = 4'hA;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        ARB_IDLE = 3'b001,
        ARB_GRANT = 3'b010,
        ARB_EXT = 3'b100
    } swa_arb_state_t;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } swa_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } swa_axi_rsp_t;

    typedef struct packed {
        logic frame;
        logic wide_req;
        logic addr_phase;
        logic dac;
        logic [31:0] upper_addr;
        logic [3:0] ucmd_n;
        logic initiator;
        logic data_drive;
        logic wide_xfer;
        logic [31:0] upper_data;
        logic [3:0] ucbe_n;
        logic devsel;
        logic peer_wide_req;
        logic rx_valid;
        logic own_req;
        logic bus_idle;
    } swa_core_t;

    typedef struct packed {
        logic [NREQ-1:0] req_n;
        logic sec_wide_request_n;
        logic [31:0] ad;
        logic [3:0] cbe_n;
        logic sec_upper_parity;
        logic central_fn;
    } swa_pin_in_t;

    typedef struct packed {
        logic sec_wide_request_n;
        logic wreq_oe;
        logic sec_wide_acknowledge_n;
        logic wack_oe;
        logic [31:0] ad;
        logic ad_oe;
        logic [3:0] cbe_n;
        logic cbe_oe;
        logic sec_upper_parity;
        logic par_oe;
    } swa_pin_out_t;
endpackage
`default_nettype wire

// ### swa_sec_wide_arb.sv
// Secondary bus wide extension pins, parity and two-level arbiter
//
// Local design decisions: the address map and register access over AXI4-Lite.
`default_nettype none
module swa_sec_wide_arb
    import swa_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire swa_axi_req_t i_axi,
    output var swa_axi_rsp_t o_axi,
    input wire swa_core_t i_core,
    input wire swa_pin_in_t i_pin,
    output var swa_pin_out_t o_pin,
    output logic [NREQ-1:0] o_gnt_n,
    output logic o_own_grant,
    output logic o_par_err
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wire [NREQ-1:0] req_sync;
    logic [31:0] ad_s1, ad_s2;
    logic [3:0] cbe_s1, cbe_s2;
    logic par_s1, par_s2, wreq_s1, wreq_s2, cen_s1, cen_s2;

    for (genvar g = 0; g < NREQ; g++)
    begin : g_req_sync
        logic s1, s2;
        always_ff @(posedge i_clock)
        begin
            s1 <= i_pin.req_n[g];
            s2 <= s1;
        end
        assign req_sync[g] = s2;
    end

    always_ff @(posedge i_clock)
    begin
        ad_s1 <= i_pin.ad;
        ad_s2 <= ad_s1;
        cbe_s1 <= i_pin.cbe_n;
        cbe_s2 <= cbe_s1;
        par_s1 <= i_pin.sec_upper_parity;
        par_s2 <= par_s1;
        wreq_s1 <= i_pin.sec_wide_request_n;
        wreq_s2 <= wreq_s1;
        cen_s1 <= i_pin.central_fn;
        cen_s2 <= cen_s1;
    end

    // ----------------------------------------
    // Register file over AXI4-Lite
    // ----------------------------------------
    logic aw_have, w_have;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data, w_mask, ctrl, stat_word, rd_word;
    logic [3:0] w_strb;
    logic perr_sticky, ext_en, chk_err;
    logic arb_en;
    logic [NARB-1:0] low_grp;
    swa_arb_state_t state, next_state;
    logic [3:0] gnt_idx, next_idx;

    wire do_wr = aw_have && w_have && !o_axi.bvalid;
    wire wr_ctrl = do_wr && aw_addr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2];
    wire wr_stat = do_wr && aw_addr[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2];

    assign arb_en = ctrl[CTRL_ARB_EN];
    assign low_grp = ctrl[CTRL_LOW_LSB +: NARB];
    assign w_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

    always_comb
    begin
        stat_word = '0;
        stat_word[STAT_EXT_EN] = ext_en;
        stat_word[STAT_PERR] = perr_sticky;
        stat_word[STAT_IDX_LSB +: 4] = gnt_idx;
        stat_word[STAT_GVALID] = state == ARB_GRANT;
        stat_word[STAT_EXT_MODE] = state == ARB_EXT;
        rd_word = '0;
        if (i_axi.araddr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2])
            rd_word = ctrl;
        else if (i_axi.araddr[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2])
            rd_word = stat_word;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_axi <= '0;
            o_axi.awready <= 1'b1;
            o_axi.wready <= 1'b1;
            o_axi.arready <= 1'b1;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end
        else
        begin
            if (i_axi.awvalid && o_axi.awready)
            begin
                aw_have <= 1'b1;
                aw_addr <= i_axi.awaddr;
                o_axi.awready <= 1'b0;
            end
            if (i_axi.wvalid && o_axi.wready)
            begin
                w_have <= 1'b1;
                w_data <= i_axi.wdata;
                w_strb <= i_axi.wstrb;
                o_axi.wready <= 1'b0;
            end
            if (do_wr)
            begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                o_axi.bvalid <= 1'b1;
                o_axi.bresp <= (wr_ctrl || wr_stat) ? RESP_OKAY : RESP_DECERR;
            end
            if (o_axi.bvalid && i_axi.bready)
            begin
                o_axi.bvalid <= 1'b0;
                o_axi.awready <= 1'b1;
                o_axi.wready <= 1'b1;
            end
            if (i_axi.arvalid && o_axi.arready)
            begin
                o_axi.arready <= 1'b0;
                o_axi.rvalid <= 1'b1;
                o_axi.rdata <= rd_word;
                o_axi.rresp <= (i_axi.araddr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2] ||
                    i_axi.araddr[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2]) ? RESP_OKAY : RESP_DECERR;
            end
            if (o_axi.rvalid && i_axi.rready)
            begin
                o_axi.rvalid <= 1'b0;
                o_axi.arready <= 1'b1;
            end
        end
    end

    // Control: arbiter enable and low-group membership
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            ctrl <= CTRL_RST;
        else if (wr_ctrl)
            ctrl <= ((ctrl & ~w_mask) | (w_data & w_mask)) & CTRL_MASK;
    end

    // Sticky parity error, set wins over write-one-clear
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            perr_sticky <= 1'b0;
        else if (chk_err)
            perr_sticky <= 1'b1;
        else if (wr_stat && w_strb[0] && w_data[STAT_PERR])
            perr_sticky <= 1'b0;
    end

    // ----------------------------------------
    // Extension enable strap
    // ----------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            ext_en <= !wreq_s2;
    end

    // ----------------------------------------
    // Wide request / acknowledge pins
    // ----------------------------------------
    logic wreq_low, wack_low;
    wire next_wreq = i_core.frame && i_core.wide_req && ext_en;
    wire next_wack = i_core.devsel && i_core.peer_wide_req && ext_en;

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_pin.sec_wide_request_n <= 1'b0;
            o_pin.wreq_oe <= cen_s2;
            wreq_low <= cen_s2;
            o_pin.sec_wide_acknowledge_n <= 1'b1;
            o_pin.wack_oe <= 1'b0;
            wack_low <= 1'b0;
        end
        else
        begin
            o_pin.sec_wide_request_n <= !next_wreq;
            o_pin.wreq_oe <= next_wreq || wreq_low;
            wreq_low <= next_wreq;
            o_pin.sec_wide_acknowledge_n <= !next_wack;
            o_pin.wack_oe <= next_wack || wack_low;
            wack_low <= next_wack;
        end
    end

    // ----------------------------------------
    // Upper address/data, byte enables, parity
    // ----------------------------------------
    logic [31:0] next_ad;
    logic [3:0] next_cbe;
    logic next_ad_oe, next_cbe_oe;

    always_comb
    begin
        next_ad = '0;
        next_cbe = i_core.ucbe_n;
        next_ad_oe = 1'b0;
        next_cbe_oe = 1'b0;
        if (!ext_en)
        begin
            next_ad_oe = 1'b1;
            next_cbe_oe = 1'b1;
            next_cbe = '0;
        end
        else if (i_core.addr_phase)
        begin
            next_ad_oe = 1'b1;
            next_cbe_oe = 1'b1;
            if (i_core.dac && i_core.wide_req)
            begin
                next_ad = i_core.upper_addr;
                next_cbe = i_core.ucmd_n;
            end
            else
                next_cbe = '0;
        end
        else if (i_core.wide_xfer)
        begin
            next_ad = i_core.upper_data;
            next_ad_oe = i_core.data_drive;
            next_cbe_oe = i_core.initiator;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_pin.ad <= '0;
            o_pin.ad_oe <= 1'b0;
            o_pin.cbe_n <= '0;
            o_pin.cbe_oe <= 1'b0;
            o_pin.sec_upper_parity <= 1'b0;
            o_pin.par_oe <= 1'b0;
        end
        else
        begin
            o_pin.ad <= next_ad;
            o_pin.ad_oe <= next_ad_oe;
            o_pin.cbe_n <= next_cbe;
            o_pin.cbe_oe <= next_cbe_oe;
            o_pin.sec_upper_parity <= ^{o_pin.ad, o_pin.cbe_n};
            o_pin.par_oe <= o_pin.ad_oe;
        end
    end

    // Received parity check, aligned to the synchronised pins
    logic [1:0] rx_d;
    logic chk_pend, chk_exp;

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            rx_d <= '0;
            chk_pend <= 1'b0;
            chk_exp <= 1'b0;
            chk_err <= 1'b0;
            o_par_err <= 1'b0;
        end
        else
        begin
            rx_d <= {rx_d[0], i_core.rx_valid && i_core.wide_xfer && ext_en};
            chk_pend <= rx_d[1];
            chk_exp <= ^{ad_s2, cbe_s2};
            chk_err <= chk_pend && (par_s2 != chk_exp);
            o_par_err <= chk_pend && (par_s2 != chk_exp);
        end
    end

    // ----------------------------------------
    // Secondary arbiter
    // ----------------------------------------
    function automatic logic [4:0] rr_pick(input logic [10:0] v, input logic [3:0] last, input logic [3:0] n);
        logic [3:0] j;
        logic [4:0] r;
        r = '0;
        j = last;
        for (int k = 0; k < 11; k++)
        begin
            j = (j + 4'h1 >= n) ? 4'h0 : j + 4'h1;
            if (v[j] && !r[4])
                r = {1'b1, j};
        end
        return r;
    endfunction

    logic [NARB-1:0] req_vec;
    logic [10:0] hi_vec;
    logic [4:0] hi_pick, lo_pick;
    logic [3:0] hi_last, lo_last, win_idx;
    logic win_ok, busy_seen;

    always_comb
    begin
        req_vec = {i_core.own_req, ~req_sync};
        hi_vec = {|(req_vec & low_grp), req_vec & ~low_grp};
        hi_pick = rr_pick(hi_vec, hi_last, HI_N);
        lo_pick = rr_pick({1'b0, req_vec & low_grp}, lo_last, LO_N);
        win_ok = hi_pick[4];
        win_idx = (hi_pick[3:0] == LOW_SLOT) ? lo_pick[3:0] : hi_pick[3:0];
    end

    always_comb
    begin
        next_state = state;
        next_idx = gnt_idx;
        case (state)
            ARB_IDLE:
                if (!arb_en)
                    next_state = ARB_EXT;
                else if (win_ok)
                begin
                    next_state = ARB_GRANT;
                    next_idx = win_idx;
                end
            ARB_GRANT:
                if (!arb_en || !req_vec[gnt_idx] ||
                    (busy_seen && i_core.bus_idle && win_ok && win_idx != gnt_idx))
                    next_state = ARB_IDLE;
            ARB_EXT:
                if (arb_en)
                    next_state = ARB_IDLE;
            default:
                next_state = ARB_IDLE;
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            state <= ARB_IDLE;
            gnt_idx <= '0;
            hi_last <= LOW_SLOT;
            lo_last <= OWN_IDX;
            busy_seen <= 1'b0;
        end
        else
        begin
            state <= next_state;
            gnt_idx <= next_idx;
            busy_seen <= (state == ARB_GRANT) && next_state == ARB_GRANT && (busy_seen || !i_core.bus_idle);
            if (state == ARB_IDLE && next_state == ARB_GRANT)
            begin
                hi_last <= hi_pick[3:0];
                if (hi_pick[3:0] == LOW_SLOT)
                    lo_last <= lo_pick[3:0];
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_gnt_n <= '1;
            o_own_grant <= 1'b0;
        end
        else if (next_state == ARB_EXT)
        begin
            o_gnt_n <= {{(NREQ-1){1'b1}}, !i_core.own_req};
            o_own_grant <= !req_sync[0] && i_core.bus_idle;
        end
        else if (next_state == ARB_GRANT)
        begin
            o_gnt_n <= ~(9'h001 << next_idx);
            o_own_grant <= next_idx == OWN_IDX;
        end
        else
        begin
            o_gnt_n <= '1;
            o_own_grant <= 1'b0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking def_clk @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    property p_ack_cause;
        (o_pin.wack_oe && !o_pin.sec_wide_acknowledge_n) |-> $past(i_core.peer_wide_req) && $past(i_core.devsel);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without wide request");

    property p_ack_devsel;
        (i_core.devsel && i_core.peer_wide_req && ext_en) |=> (o_pin.wack_oe && !o_pin.sec_wide_acknowledge_n);
    endproperty
    a_ack_devsel: assert property (p_ack_devsel) else $error("ack not with devsel");

    property p_req_release;
        (o_pin.wreq_oe && !o_pin.sec_wide_request_n) ##1 o_pin.sec_wide_request_n
            |-> o_pin.wreq_oe ##1 (!o_pin.wreq_oe || !o_pin.sec_wide_request_n);
    endproperty
    a_req_release: assert property (p_req_release) else $error("wide request release wrong");

    property p_req_frame;
        (i_core.frame && i_core.wide_req && ext_en) |=> (o_pin.wreq_oe && !o_pin.sec_wide_request_n);
    endproperty
    a_req_frame: assert property (p_req_frame) else $error("wide request not with frame");

    property p_req_in_reset;
        @(posedge i_clock) disable iff (1'b0)
        ($past(i_rst) && $past(cen_s2)) |-> (o_pin.wreq_oe && !o_pin.sec_wide_request_n);
    endproperty
    a_req_in_reset: assert property (p_req_in_reset) else $error("no wide request in reset");

    property p_par_value;
        o_pin.ad_oe |=> o_pin.sec_upper_parity == ^{$past(o_pin.ad), $past(o_pin.cbe_n)};
    endproperty
    a_par_value: assert property (p_par_value) else $error("upper parity wrong");

    property p_par_tristate;
        (o_pin.ad_oe ##1 !o_pin.ad_oe) |-> o_pin.par_oe ##1 !o_pin.par_oe;
    endproperty
    a_par_tristate: assert property (p_par_tristate) else $error("parity release wrong");

    property p_disabled_drive;
        (!ext_en && !$past(i_rst, 2)) |-> (o_pin.ad_oe && o_pin.cbe_oe && o_pin.par_oe);
    endproperty
    a_disabled_drive: assert property (p_disabled_drive) else $error("disabled lines undriven");

    property p_par_check;
        rx_d[1] ##1 (par_s2 != $past(^{ad_s2, cbe_s2})) |=> o_par_err;
    endproperty
    a_par_check: assert property (p_par_check) else $error("parity error missed");

    property p_one_grant;
        (state != ARB_EXT) |-> $onehot0({~o_gnt_n, o_own_grant});
    endproperty
    a_one_grant: assert property (p_one_grant) else $error("more than one grant");

    property p_grant_gap;
        (state != ARB_EXT && $past(state) != ARB_EXT && (o_own_grant || !(&o_gnt_n))
            && ($past(o_own_grant) || !(&$past(o_gnt_n))))
            |-> (o_gnt_n == $past(o_gnt_n) && o_own_grant == $past(o_own_grant));
    endproperty
    a_grant_gap: assert property (p_grant_gap) else $error("grant switched without gap");

    property p_ext_request;
        (state == ARB_EXT) |-> o_gnt_n[0] == !$past(i_core.own_req);
    endproperty
    a_ext_request: assert property (p_ext_request) else $error("external request wrong");

    property p_ext_grant;
        (state == ARB_EXT && o_own_grant) |-> $past(!req_sync[0] && i_core.bus_idle);
    endproperty
    a_ext_grant: assert property (p_ext_grant) else $error("own grant without external grant");
endmodule
`default_nettype wire

// ### swa_bus_peer.sv
// Behavioural requesters standing on the far side of the secondary bus
`default_nettype none
module swa_bus_peer
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [8:0] i_want,
    input wire logic [8:0] i_gnt_n,
    input wire logic i_bus_idle,
    output logic [8:0] o_req_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] busy [9];
    // Short transaction once granted; request dropped when done
    always @(posedge i_clock)
    begin
        for (int i = 0; i < 9; i++)
        begin
            if (i_rst || !i_want[i])
                busy[i] <= 2'h0;
            else if (!i_gnt_n[i] && i_bus_idle && busy[i] != 2'h3)
                busy[i] <= busy[i] + 2'h1;
            o_req_n[i] <= i_rst || !(i_want[i] && busy[i] != 2'h3);
        end
    end
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the secondary wide extension and arbiter
`default_nettype none
module testbench
    import swa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam swa_core_t IDLE = '{bus_idle: 1'b1, default: '0};
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    swa_axi_req_t axi = '0;
    swa_axi_rsp_t rsp;
    swa_core_t core = IDLE;
    swa_pin_in_t pin_in;
    swa_pin_out_t pin_out;
    logic [8:0] want = '0;
    logic [8:0] req_n;
    logic [8:0] gnt_n;
    logic own_gnt;
    logic par_err;
    logic [31:0] ad_in = '0;
    logic [3:0] cbe_in = '0;
    logic par_in = 1'b0;
    logic central = 1'b1;
    logic ext = 1'b0;
    logic [1:0] wq;
    logic [1:0] wa;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;

    always #12.5 i_clock = ~i_clock;
    // Pull-up holds the wide request line when nobody drives it
    assign pin_in = {req_n, pin_out.wreq_oe ? pin_out.sec_wide_request_n : 1'b1, ad_in, cbe_in, par_in, central};
    assign wq = {pin_out.sec_wide_request_n, pin_out.wreq_oe};
    assign wa = {pin_out.sec_wide_acknowledge_n, pin_out.wack_oe};

    swa_sec_wide_arb dut (.i_clock(i_clock), .i_rst(i_rst), .i_axi(axi), .o_axi(rsp), .i_core(core),
        .i_pin(pin_in), .o_pin(pin_out), .o_gnt_n(gnt_n), .o_own_grant(own_gnt), .o_par_err(par_err));
    swa_bus_peer peer (.i_clock(i_clock), .i_rst(i_rst), .i_want(want), .i_gnt_n(gnt_n),
        .i_bus_idle(core.bus_idle), .o_req_n(req_n));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge i_clock)
    begin
        cycles++;
        if (!i_rst && !ext && ($countones(~gnt_n) + own_gnt) > 1)
            check(32'h0, 32'h1);
        if (cycles == 5000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        axi.awvalid <= 1'b1;
        axi.awaddr <= a;
        axi.wvalid <= 1'b1;
        axi.wdata <= d;
        axi.wstrb <= 4'hF;
        axi.bready <= 1'b1;
        do
        begin
            @(posedge i_clock);
            if (rsp.awready)
                axi.awvalid <= 1'b0;
            if (rsp.wready)
                axi.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        axi.bready <= 1'b0;
        check(rsp.bresp, er);
        tick(1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
        axi.arvalid <= 1'b1;
        axi.araddr <= a;
        axi.rready <= 1'b1;
        do
        begin
            @(posedge i_clock);
            if (rsp.arready)
                axi.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        axi.rready <= 1'b0;
        check({rsp.rdata & m}, e);
        check(rsp.rresp, er);
        tick(1);
    endtask

    task automatic do_reset(input logic c);
        i_rst <= 1'b1;
        central <= c;
        ext <= 1'b0;
        tick(6);
        check(pin_out.wreq_oe & ~pin_out.sec_wide_request_n, c);
        i_rst <= 1'b0;
        tick(1);
    endtask

    task automatic wide(input logic ack);
        core.frame <= !ack;
        core.wide_req <= !ack;
        core.devsel <= ack;
        core.peer_wide_req <= ack;
        tick(2);
        check(ack ? wa : wq, 2'b01);
        core <= IDLE;
        tick(2);
        check(ack ? wa : wq, 2'b11);
        tick(1);
        check(ack ? wa[0] : wq[0], 1'b0);
        core.devsel <= 1'b1;
        tick(3);
        check(wa[0], 1'b0);
        core <= IDLE;
        tick(1);
    endtask

    task automatic upper(input logic dp);
        core.frame <= 1'b1;
        core.wide_req <= 1'b1;
        core.initiator <= 1'b1;
        core.addr_phase <= !dp;
        core.dac <= !dp;
        core.data_drive <= dp;
        core.wide_xfer <= dp;
        core.upper_addr <= 32'hA5C3_0F81;
        core.upper_data <= 32'hA5C3_0F81;
        core.ucmd_n <= 4'hD;
        core.ucbe_n <= 4'hD;
        tick(2);
        check(pin_out.ad, 32'hA5C3_0F81);
        check({pin_out.ad_oe, pin_out.cbe_oe, pin_out.cbe_n}, 6'h3D);
        core <= IDLE;
        tick(1);
        check({pin_out.par_oe, pin_out.sec_upper_parity}, {1'b1, ^{32'hA5C3_0F81, 4'hD}});
    endtask

    task automatic rx(input logic bad);
        int hits;
        hits = 0;
        ad_in <= 32'h1234_5678;
        cbe_in <= 4'h6;
        core.ucbe_n <= 4'h6;
        core.rx_valid <= 1'b1;
        core.wide_xfer <= 1'b1;
        tick(1);
        core <= IDLE;
        par_in <= ^{32'h1234_5678, 4'h6} ^ bad;
        repeat (8)
        begin
            tick(1);
            if (par_err === 1'b1)
                hits++;
        end
        check(hits, bad);
    endtask

    task automatic next_gnt(input logic [8:0] e);
        int t;
        t = 0;
        while (gnt_n === 9'h1FF && t < 20)
        begin
            tick(1);
            t++;
        end
        check({~gnt_n}, e);
        while (gnt_n !== 9'h1FF && t < 40)
        begin
            tick(1);
            t++;
        end
    endtask

    initial
    begin
        do_reset(1'b1);
        rd_chk(CTRL_OFS, 32'hFFFF_FFFF, CTRL_RST, RESP_OKAY);
        rd_chk(STAT_OFS, 32'h1, 32'h1, RESP_OKAY);
        rd_chk(8'h08, 32'hFFFF_FFFF, 32'h0, RESP_DECERR);
        axi_wr(8'h0C, 32'hFFFF_FFFF, RESP_DECERR);
        axi_wr(CTRL_OFS, 32'hFFFF_FFFF, RESP_OKAY);
        rd_chk(CTRL_OFS, 32'hFFFF_FFFF, CTRL_MASK, RESP_OKAY);
        axi_wr(CTRL_OFS, CTRL_RST, RESP_OKAY);
        wide(1'b0);
        wide(1'b1);
        upper(1'b0);
        upper(1'b1);
        rx(1'b0);
        rx(1'b1);
        rd_chk(STAT_OFS, 32'h2, 32'h2, RESP_OKAY);
        want <= 9'h008;
        next_gnt(9'h008);
        want <= 9'h006;
        next_gnt(9'h002);
        next_gnt(9'h004);
        want <= 9'h000;
        axi_wr(CTRL_OFS, 32'h0010_0001, RESP_OKAY);
        want <= 9'h030;
        next_gnt(9'h020);
        next_gnt(9'h010);
        want <= 9'h000;
        axi_wr(CTRL_OFS, 32'h0, RESP_OKAY);
        ext <= 1'b1;
        core.own_req <= 1'b1;
        core.bus_idle <= 1'b0;
        want <= 9'h001;
        tick(4);
        check({gnt_n[0], own_gnt}, 2'b00);
        core.bus_idle <= 1'b1;
        tick(2);
        check(own_gnt, 1'b1);
        want <= 9'h000;
        core <= IDLE;
        do_reset(1'b0);
        rd_chk(STAT_OFS, 32'h1, 32'h0, RESP_OKAY);
        core.frame <= 1'b1;
        core.wide_req <= 1'b1;
        tick(2);
        check({pin_out.ad_oe, pin_out.cbe_oe, pin_out.par_oe, wq[0]}, 4'hE);
        print_verdict();
    end
endmodule
`default_nettype wire
